// file: design/pss_ctrl.sv
`timescale 1ns/10ps
// What this block does
// [R1] Charger on/off from enable bit; 3-bit code picks 2.50 V to 3.30 V.
// [R2] High charge current in ON; reduced current in Sleep or Standby.
// [R3] No charging in OFF or while main supply is below undervoltage.
// [R4] Main supply below low threshold switches logic supply to backup cell.
// [R5] Each warning threshold crossing, either direction, raises its own event.
// [R6] Sense register shows the current die temperature range.
// [R7] Over-temperature shutdown only after 8.0 ms of persistent condition.
// [R8] Five power states: ON, OFF, Sleep, Standby, Coin Cell.
// [R9] Turn on only with supply above rising threshold and either enable asserted or an auto-restart pending.
// [R10] Supply below falling threshold in ON moves to Coin Cell.
// [R11] Interrupt output only active in Sleep, Standby and ON.
// [R12] Power-good released in ON, driven low in OFF.
// [R13] Config 0, off mode 0: power off as soon as enable goes low.
// [R14] Config 1, off mode 0, long press on: off after enable low 4.0 s.
// [R15] Auto-restart bit restarts after an enable-pin power-off.
// [R16] Turn-on ignored during thermal protection until temperature released.
// [R17] Qualified low-power request enters Standby; its release leaves Standby.
// [R18] Internal request is pin level XOR polarity invert bit 6 at 0x1B.
// [R19] Low-power request pin only acts while in ON.
// [R20] At first power-up standby settings are copied from ON settings.
// [R21] Standby delay of 0 to 3 slow periods, default one.
// [R22] Request synchronised through three slow clock cycles before the delay.
// [R23] Coin Cell rejects turn-on, holds power-good low, leaves to OFF on supply.
// [R24] Enable low with off mode set enters Sleep; enable high leaves it.
// [R25] Delay counts on slow clock and restarts when the request changes.
// [R26] Control bits return to defaults on re-initialisation from Coin Cell.
module pss_ctrl #(
  parameter int THERM_DEB  = pss_pkg::THERM_DEB_CYC,
  parameter int LONG_PRESS = pss_pkg::LONG_PRESS_CYC,
  parameter int SLOW_DIV   = pss_pkg::SLOW_DIV_CYC
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic [7:0]                 reg_rdata_o,
  // Supply comparators
  input  wire logic                  main_supply_above_uv_i,
  input  wire logic                  main_supply_above_low_i,
  // Temperature comparators: 110, 120, 125, 130 and protection
  input  wire logic [3:0]            temp_above_warn_i,
  input  wire logic                  temp_above_prot_i,
  input  wire logic                  temp_below_release_i,
  // Pins and fuse configuration
  input  wire logic                  enable_pin_i,
  input  wire logic                  lowpower_req_pin_i,
  input  wire logic                  en_cfg_i,
  input  wire logic                  off_mode_sel_i,
  input  wire logic                  long_press_off_en_i,
  input  wire logic                  auto_restart_en_i,
  // Outputs
  output pss_pkg::pss_state_type     power_state_o,
  output logic                       power_good_reset_n_o,
  output logic                       power_good_reset_n_oe_o,
  output logic                       irq_out_n_o,
  output logic [3:0]                 temp_event_o,
  output logic [3:0]                 temp_sense_bits_o,
  output logic                       coin_charge_on_o,
  output logic                       charge_current_high_o,
  output logic [2:0]                 coin_voltage_sel_o,
  output logic                       backup_supply_sel_o,
  output logic                       standby_copy_o
);
  import pss_pkg::*;

  localparam int TW = $clog2(THERM_DEB + 1);
  localparam int LW = $clog2(LONG_PRESS + 1);

  // ==========================================================
  // Elaboration checks
  if (THERM_DEB < 1) begin : g_chk_deb
    $error("pss_ctrl: debounce count must be at least one");
  end
  if (LONG_PRESS < 1) begin : g_chk_press
    $error("pss_ctrl: long-press count must be at least one");
  end
  // A divider below two ticks every cycle and collapses the sync stages
  if (SLOW_DIV < 2) begin : g_chk_div
    $error("pss_ctrl: slow divider must be at least two");
  end

  // ==========================================================
  // State
  typedef struct packed {
    pss_state_type st;
    // Only live control bits are stored; reserved bits read back as zero
    logic [3:0]    coin_ctrl;
    logic [2:0]    pwr_ctrl;
    logic [7:0]    rdata;
    logic [3:0]    warn_prev;
    logic [3:0]    event_p;
    logic          irq_n;
    logic [TW-1:0] therm_cnt;
    logic          therm_lock;
    logic [LW-1:0] press_cnt;
    logic          restart_pend;
    logic          first_up;
    logic          copy_p;
    logic          pg_oe;
    logic          chg_on;
    logic          chg_hi;
    logic          backup_sel;
  } pss_ctrl_type;

  pss_ctrl_type s_q, s_d;
  logic         lp_req_qual;
  logic         therm_trip;
  logic         press_done;
  logic         supply_down;
  logic         lp_req_level;

  function automatic logic irq_allowed(input pss_state_type st);
    irq_allowed = (st == PSS_ON) || (st == PSS_LOWPOWER_REQ_PIN) || (st == PSS_SLEEP);
  endfunction : irq_allowed

  function automatic logic pin_off(input logic en, input logic cfg, input logic lp_en,
                                   input logic omode, input logic done);
    pin_off = !en && !omode && (!cfg || (lp_en && done));
  endfunction : pin_off

  // ==========================================================
  // Standby request qualification
  pss_lp_qual #(
    .DIV_CYC     (SLOW_DIV)
  ) u_lp_qual (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .req_level_i (lp_req_level),
    .delay_sel_i (s_q.pwr_ctrl[1:0]),                                          // [R21]
    .req_qual_o  (lp_req_qual)
  );

  assign therm_trip  = (s_q.therm_cnt == TW'(THERM_DEB));
  assign press_done  = (s_q.press_cnt == LW'(LONG_PRESS));
  assign supply_down = !main_supply_above_uv_i;
  assign lp_req_level = lowpower_req_pin_i ^ s_q.pwr_ctrl[LP_INV_BIT-LP_DLY_LSB];   // [R18]

  always_comb begin
    s_d         = s_q;
    s_d.event_p = 4'h0;
    s_d.copy_p  = 1'b0;

    // ==========================================================
    // Register writes
    if (reg_wr_i && reg_addr_i == COIN_CTRL_OFFS) begin
      s_d.coin_ctrl = reg_wdata_i[COIN_EN_BIT:COIN_VSEL_LSB];                 // [R1]
    end
    if (reg_wr_i && reg_addr_i == PWR_CTRL_OFFS) begin
      s_d.pwr_ctrl = reg_wdata_i[LP_INV_BIT:LP_DLY_LSB];                      // [R18]
    end

    // ==========================================================
    // Register reads, one cycle behind the address
    case (reg_addr_i)
      COIN_CTRL_OFFS: s_d.rdata = {4'h0, s_q.coin_ctrl};
      PWR_CTRL_OFFS:  s_d.rdata = {1'b0, s_q.pwr_ctrl, 4'h0};
      SENSE_OFFS:     s_d.rdata = {3'h0, s_q.therm_lock, s_q.warn_prev};      // [R6]
      default:        s_d.rdata = 8'h00;
    endcase

    // ==========================================================
    // Thermal warnings and debounced protection
    s_d.warn_prev = temp_above_warn_i;
    s_d.event_p   = temp_above_warn_i ^ s_q.warn_prev;                        // [R5]
    // Count saturates at the trip value so it never wraps
    if (!temp_above_prot_i) begin
      s_d.therm_cnt = '0;                                                     // [R7]
    end else if (!therm_trip) begin
      s_d.therm_cnt = s_q.therm_cnt + TW'(1);                                 // [R7]
    end
    if (s_q.therm_lock && temp_below_release_i && !temp_above_prot_i) begin
      s_d.therm_lock = 1'b0;                                                  // [R16]
    end

    // ==========================================================
    // Enable pin hold timer
    if (enable_pin_i) begin
      s_d.press_cnt = '0;
    end else if (!press_done) begin
      s_d.press_cnt = s_q.press_cnt + LW'(1);                                 // [R14]
    end

    // ==========================================================
    // Power state machine
    case (s_q.st)                                                             // [R8]
      PSS_COIN: begin
        // Re-init outranks a register write in the same cycle
        if (main_supply_above_uv_i) begin                                     // [R23]
          s_d.st           = PSS_OFF;
          s_d.coin_ctrl    = COIN_CTRL_RESET[COIN_EN_BIT:COIN_VSEL_LSB];      // [R26]
          s_d.pwr_ctrl     = PWR_CTRL_RESET[LP_INV_BIT:LP_DLY_LSB];           // [R26]
          s_d.restart_pend = 1'b0;
          s_d.first_up     = 1'b1;
        end
      end

      // Thermal lock outranks a pending restart
      PSS_OFF: begin
        if (supply_down) begin
          s_d.st = PSS_COIN;
        end else if (s_q.therm_lock) begin
          s_d.st = PSS_OFF;                                                   // [R16]
        end else if (enable_pin_i || s_q.restart_pend) begin
          s_d.st           = PSS_ON;                                          // [R9]
          s_d.restart_pend = 1'b0;                                            // [R15]
          s_d.copy_p       = s_q.first_up;                                    // [R20]
          s_d.first_up     = 1'b0;
        end
      end

      // Supply, then thermal, then sleep, then pin-off, then standby
      PSS_ON, PSS_LOWPOWER_REQ_PIN: begin
        if (supply_down) begin
          s_d.st = PSS_COIN;                                                  // [R10]
        end else if (therm_trip) begin
          s_d.st         = PSS_OFF;                                           // [R7]
          s_d.therm_lock = 1'b1;
        end else if (!enable_pin_i && off_mode_sel_i) begin
          s_d.st = PSS_SLEEP;                                                 // [R24]
        end else if (pin_off(enable_pin_i, en_cfg_i, long_press_off_en_i,
                             off_mode_sel_i, press_done)) begin
          s_d.st           = PSS_OFF;                                         // [R13] [R14]
          s_d.restart_pend = auto_restart_en_i;                               // [R15]
        end else if (s_q.st == PSS_ON && lp_req_qual) begin
          s_d.st = PSS_LOWPOWER_REQ_PIN;                                                  // [R17] [R19]
        end else if (s_q.st == PSS_LOWPOWER_REQ_PIN && !lp_req_qual) begin
          s_d.st = PSS_ON;                                                    // [R17]
        end
      end

      PSS_SLEEP: begin
        if (supply_down) begin
          s_d.st = PSS_COIN;
        end else if (therm_trip) begin
          s_d.st         = PSS_OFF;
          s_d.therm_lock = 1'b1;
        end else if (enable_pin_i) begin
          s_d.st = PSS_ON;                                                    // [R24]
        end
      end

      default: begin
        s_d.st = PSS_COIN;
      end
    endcase

    // ==========================================================
    // Outputs follow the next state so they align with it
    s_d.irq_n      = !(irq_allowed(s_d.st) && (|s_d.event_p));                // [R11]
    s_d.pg_oe      = (s_d.st != PSS_ON) && (s_d.st != PSS_LOWPOWER_REQ_PIN)
                     && (s_d.st != PSS_SLEEP);                                // [R12] [R23]

    // ==========================================================
    // Charger follows the next state as well; backup select follows the low comparator
    s_d.chg_on     = s_d.coin_ctrl[COIN_EN_BIT] && main_supply_above_uv_i
                     && irq_allowed(s_d.st);                                  // [R1] [R3]
    s_d.chg_hi     = (s_d.st == PSS_ON);                                      // [R2]
    // Switch-over happens even with nothing on the backup pin
    s_d.backup_sel = !main_supply_above_low_i;                                // [R4]
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_q           <= '0;
      s_q.st        <= PSS_COIN;
      s_q.coin_ctrl <= COIN_CTRL_RESET[COIN_EN_BIT:COIN_VSEL_LSB];
      s_q.pwr_ctrl  <= PWR_CTRL_RESET[LP_INV_BIT:LP_DLY_LSB];
      s_q.irq_n     <= 1'b1;
      s_q.first_up  <= 1'b1;
      s_q.pg_oe     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Output map, straight from flops except the power-good data tied low
  assign power_state_o           = s_q.st;
  // Open-drain data stays low; only the enable moves the pin
  assign power_good_reset_n_o    = 1'b0;
  assign power_good_reset_n_oe_o = s_q.pg_oe;
  assign irq_out_n_o             = s_q.irq_n;

  // ==========================================================
  // Thermal status
  assign temp_event_o            = s_q.event_p;
  assign temp_sense_bits_o       = s_q.warn_prev;

  // ==========================================================
  // Charger and supply
  assign coin_charge_on_o        = s_q.chg_on;
  assign charge_current_high_o   = s_q.chg_hi;
  assign coin_voltage_sel_o      = s_q.coin_ctrl[2:0];
  assign backup_supply_sel_o     = s_q.backup_sel;
  assign standby_copy_o          = s_q.copy_p;

  // ==========================================================
  // Register read
  assign reg_rdata_o             = s_q.rdata;
endmodule : pss_ctrl

// file: design/pss_pkg.sv
package pss_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] COIN_CTRL_OFFS   = 8'h1A;
  localparam logic [7:0] PWR_CTRL_OFFS    = 8'h1B;
  localparam logic [7:0] SENSE_OFFS       = 8'h07;
  localparam logic [7:0] COIN_CTRL_RESET  = 8'h00;
  localparam logic [7:0] PWR_CTRL_RESET   = 8'h10;
  localparam int         COIN_VSEL_LSB    = 0;
  localparam int         COIN_EN_BIT      = 3;
  localparam int         LP_DLY_LSB       = 4;
  localparam int         LP_INV_BIT       = 6;
  localparam int         SENSE_PROT_BIT   = 4;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint SLOW_CLK_HZ     = 32_768;
  localparam longint THERM_DEB_US    = 8_000;
  localparam longint LONG_PRESS_MS   = 4_000;
  localparam int     SYNC_STAGES     = 3;
  localparam int     SLOW_DIV_CYC    = int'(CLK_HZ / SLOW_CLK_HZ);
  localparam int     THERM_DEB_CYC   = int'((THERM_DEB_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int     LONG_PRESS_CYC  = int'((LONG_PRESS_MS * CLK_HZ) / 1_000 + 1);

  // ==========================================================
  // Power states, Gray along OFF-ON-LOWPOWER_REQ_PIN-SLEEP-COIN
  typedef enum logic [2:0] {
    PSS_OFF   = 3'h0,
    PSS_ON    = 3'h1,
    PSS_LOWPOWER_REQ_PIN  = 3'h3,
    PSS_SLEEP = 3'h2,
    PSS_COIN  = 3'h6
  } pss_state_type;
endpackage : pss_pkg

// file: design/pss_lp_qual.sv
`timescale 1ns/10ps
module pss_lp_qual #(
  parameter int DIV_CYC = pss_pkg::SLOW_DIV_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_level_i,
  input  wire logic [1:0] delay_sel_i,
  output logic            req_qual_o
);
  import pss_pkg::*;

  localparam int DW = $clog2(DIV_CYC + 1);

  if (DIV_CYC < 2) begin : g_chk
    $error("pss_lp_qual: DIV_CYC too small");
  end

  typedef struct packed {
    logic [DW-1:0]          div;
    logic                   tick;
    logic [SYNC_STAGES-1:0] sync;
    logic [1:0]             dly;
    logic                   qual;
  } pss_qual_type;

  pss_qual_type s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    // ==========================================================
    // Slow tick from the system clock
    if (s_q.div == DW'(DIV_CYC - 1)) begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + DW'(1);
    end
    // ==========================================================
    // Three slow-clock stages, then a programmable hold-off
    if (s_q.tick) begin
      s_d.sync = {s_q.sync[SYNC_STAGES-2:0], req_level_i};                  // [R22]
      if (s_q.sync[SYNC_STAGES-1] == s_q.qual) begin
        s_d.dly = '0;                                                        // [R25]
      end else if (s_q.dly >= delay_sel_i) begin
        s_d.qual = s_q.sync[SYNC_STAGES-1];                                  // [R21]
        s_d.dly  = '0;
      end else begin
        s_d.dly = s_q.dly + 2'h1;                                            // [R25]
      end
    end
    // Zero delay updates the qualified level on the first tick that sees the sync output differ
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_qual_o = s_q.qual;
endmodule : pss_lp_qual

// file: bench/pss_ctrl_chk.sv
`timescale 1ns/10ps
module pss_ctrl_chk (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  input wire logic                   main_supply_above_uv_i,
  input wire logic                   main_supply_above_low_i,
  input wire logic [3:0]             temp_above_warn_i,
  input wire pss_pkg::pss_state_type power_state_o,
  input wire logic                   power_good_reset_n_oe_o,
  input wire logic                   irq_out_n_o,
  input wire logic [3:0]             temp_event_o,
  input wire logic [3:0]             temp_sense_bits_o,
  input wire logic                   coin_charge_on_o,
  input wire logic                   charge_current_high_o,
  input wire logic                   backup_supply_sel_o
);
  import pss_pkg::*;
  // ==========
  // Checks
  logic act;
  assign act = power_state_o inside {PSS_ON, PSS_LOWPOWER_REQ_PIN, PSS_SLEEP};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_pg_follows_state: assert property (power_good_reset_n_oe_o == !act)
    else $error("pg drive wrong for state");
  a_irq_when_active: assert property (!irq_out_n_o |-> act || $past(act))
    else $error("irq outside active states");
  a_event_on_change: assert property (
    temp_event_o == ($past(temp_above_warn_i) ^ $past(temp_above_warn_i, 2)))
    else $error("temp event mismatch");
  a_sense_copy: assert property (temp_sense_bits_o == $past(temp_above_warn_i))
    else $error("sense bits stale");
  a_idle_no_charge: assert property (!act |-> !coin_charge_on_o)
    else $error("charging while idle");
  a_uv_stops_charge: assert property (!main_supply_above_uv_i |=> !coin_charge_on_o)
    else $error("charging under undervoltage");
  a_high_only_on: assert property (charge_current_high_o |-> power_state_o == PSS_ON)
    else $error("high current outside on");
  a_uv_to_coin: assert property (
    power_state_o == PSS_ON && !main_supply_above_uv_i |=> power_state_o == PSS_COIN)
    else $error("no coin state on supply loss");
  a_backup_switch: assert property (!main_supply_above_low_i |=> backup_supply_sel_o)
    else $error("backup supply not selected");
endmodule : pss_ctrl_chk

bind pss_ctrl pss_ctrl_chk chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .main_supply_above_uv_i(main_supply_above_uv_i),
  .main_supply_above_low_i(main_supply_above_low_i),
  .temp_above_warn_i(temp_above_warn_i), .power_state_o(power_state_o),
  .power_good_reset_n_oe_o(power_good_reset_n_oe_o), .irq_out_n_o(irq_out_n_o),
  .temp_event_o(temp_event_o), .temp_sense_bits_o(temp_sense_bits_o),
  .coin_charge_on_o(coin_charge_on_o), .charge_current_high_o(charge_current_high_o),
  .backup_supply_sel_o(backup_supply_sel_o)
);

// file: bench/pss_host_model.sv
`timescale 1ns/10ps
module pss_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            enable_pin_o,
  output logic            lowpower_req_pin_o
);
  // ==========
  // Host pins and register port
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    enable_pin_o = 1'b0;
    lowpower_req_pin_o = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;  // Stale data must not look valid
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    d = reg_rdata_i;
  endtask : rd_reg
  task automatic set_pins(input logic en, input logic lp);
    @(posedge clk_sys_i);
    enable_pin_o       <= en;
    lowpower_req_pin_o <= lp;
  endtask : set_pins
endmodule : pss_host_model

// file: bench/pss_ctrl_test.sv
`timescale 1ns/10ps
module pss_ctrl_test;
  import pss_pkg::*;
  // ==========
  // Harness
  logic          clk_sys_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          uv = 1'b0;
  logic          lowv = 1'b0;
  logic          prot = 1'b0;
  logic          rel = 1'b1;
  logic          omode = 1'b0;
  logic          cfg = 1'b0;
  logic          lpen = 1'b0;
  logic          arst = 1'b0;
  logic [3:0]    warn = 4'h0;
  logic [7:0]    addr, wdata, rdata;
  logic          wr, en, lp, oe, pgn, irqn, chg, hi, bk, cpy;
  logic [3:0]    ev, sense;
  logic [2:0]    vsel;
  pss_state_type st;
  wire           pg_pin = oe ? pgn : 1'b1;  // External pull-up
  int            fails = 0;
  int            checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  pss_host_model host_u (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .enable_pin_o(en), .lowpower_req_pin_o(lp));
  // Short counts keep the run small
  pss_ctrl #(.THERM_DEB(20), .LONG_PRESS(30), .SLOW_DIV(4)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .main_supply_above_uv_i(uv),
    .main_supply_above_low_i(lowv), .temp_above_warn_i(warn), .temp_above_prot_i(prot),
    .temp_below_release_i(rel), .enable_pin_i(en), .lowpower_req_pin_i(lp),
    .en_cfg_i(cfg), .off_mode_sel_i(omode), .long_press_off_en_i(lpen),
    .auto_restart_en_i(arst), .power_state_o(st), .power_good_reset_n_o(pgn),
    .power_good_reset_n_oe_o(oe), .irq_out_n_o(irqn), .temp_event_o(ev),
    .temp_sense_bits_o(sense), .coin_charge_on_o(chg), .charge_current_high_o(hi),
    .coin_voltage_sel_o(vsel), .backup_supply_sel_o(bk), .standby_copy_o(cpy));
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd_reg(a, d);
    chk(nm, e, d);
  endtask : rdchk
  task automatic wait_st(input pss_state_type s, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys_i);
      if (st === s) return;
    end
    chk("state", 8'(s), 8'(st));
    wrap_up();
  endtask : wait_st
  task automatic nwait(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : nwait
  // ==========
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    nwait(1);
    chk("state", 8'(PSS_COIN), 8'(st));
    rdchk("coin", COIN_CTRL_OFFS, COIN_CTRL_RESET);
    rdchk("pwr", PWR_CTRL_OFFS, PWR_CTRL_RESET);
    host_u.set_pins(1'b1, 1'b0);
    nwait(5);
    chk("state", 8'(PSS_COIN), 8'(st));
    chk("pg", 8'h00, 8'(pg_pin));
    chk("backup", 8'h01, 8'(bk));
    @(posedge clk_sys_i);
    uv <= 1'b1;
    lowv <= 1'b1;
    wait_st(PSS_ON, 5);
    chk("copy", 8'h01, 8'(cpy));
    nwait(1);
    chk("pg", 8'h01, 8'(pg_pin));
    chk("backup", 8'h00, 8'(bk));
    for (int c = 0; c < 8; c++) begin
      host_u.wr_reg(COIN_CTRL_OFFS, 8'(8 + c));
      nwait(2);
      chk("vsel", 8'(c), 8'(vsel));
      chk("chg", 8'h01, 8'(chg));
      chk("hi", 8'h01, 8'(hi));
    end
    host_u.wr_reg(COIN_CTRL_OFFS, 8'hF3);
    rdchk("coin", COIN_CTRL_OFFS, 8'h03);
    chk("chg", 8'h00, 8'(chg));
    rdchk("unmapped", 8'h03, 8'h00);
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_sys_i);
      warn[b] <= 1'b1;
      nwait(2);
      chk("event", 8'(1 << b), 8'(ev));
      chk("irq", 8'h00, 8'(irqn));
      chk("sense", 8'(warn), 8'(sense));
    end
    rdchk("sensereg", SENSE_OFFS, 8'h0F);
    @(posedge clk_sys_i);
    warn <= 4'h0;
    nwait(2);
    chk("event", 8'h0F, 8'(ev));
    // Standby: pin high with default polarity and delay
    host_u.wr_reg(COIN_CTRL_OFFS, 8'h08);
    host_u.set_pins(1'b1, 1'b1);
    wait_st(PSS_LOWPOWER_REQ_PIN, 40);
    host_u.set_pins(1'b1, 1'b0);
    nwait(10);
    chk("state", 8'(PSS_LOWPOWER_REQ_PIN), 8'(st));
    chk("hi", 8'h00, 8'(hi));
    chk("chg", 8'h01, 8'(chg));
    wait_st(PSS_ON, 40);
    host_u.wr_reg(PWR_CTRL_OFFS, 8'h50);
    wait_st(PSS_LOWPOWER_REQ_PIN, 40);
    host_u.set_pins(1'b1, 1'b1);
    wait_st(PSS_ON, 40);
    // Enable pin off, then sleep
    host_u.set_pins(1'b0, 1'b1);
    wait_st(PSS_OFF, 3);
    nwait(1);
    chk("chg", 8'h00, 8'(chg));
    chk("pg", 8'h00, 8'(pg_pin));
    @(posedge clk_sys_i);
    warn <= 4'h1;
    nwait(2);
    chk("irq", 8'h01, 8'(irqn));
    host_u.set_pins(1'b1, 1'b1);
    wait_st(PSS_ON, 3);
    chk("copy", 8'h00, 8'(cpy));
    @(posedge clk_sys_i);
    omode <= 1'b1;
    host_u.set_pins(1'b0, 1'b1);
    wait_st(PSS_SLEEP, 3);
    host_u.set_pins(1'b1, 1'b1);
    wait_st(PSS_ON, 3);
    // Thermal trip is debounced, then holds off turn-on
    @(posedge clk_sys_i);
    omode <= 1'b0;
    prot <= 1'b1;
    rel <= 1'b0;
    nwait(18);
    chk("state", 8'(PSS_ON), 8'(st));
    wait_st(PSS_OFF, 6);
    nwait(5);
    chk("state", 8'(PSS_OFF), 8'(st));
    @(posedge clk_sys_i);
    prot <= 1'b0;
    rel <= 1'b1;
    wait_st(PSS_ON, 4);
    // Long press with auto restart: off only after the hold, then back on
    @(posedge clk_sys_i);
    cfg <= 1'b1;
    lpen <= 1'b1;
    arst <= 1'b1;
    host_u.set_pins(1'b0, 1'b1);
    nwait(20);
    chk("state", 8'(PSS_ON), 8'(st));
    wait_st(PSS_OFF, 20);
    host_u.set_pins(1'b1, 1'b1);
    nwait(1);
    chk("state", 8'(PSS_ON), 8'(st));
    @(posedge clk_sys_i);
    cfg <= 1'b0;
    lpen <= 1'b0;
    arst <= 1'b0;
    @(posedge clk_sys_i);
    uv <= 1'b0;
    lowv <= 1'b0;
    wait_st(PSS_COIN, 3);
    nwait(1);
    chk("backup", 8'h01, 8'(bk));
    // Supply back: re-init restores the control registers
    @(posedge clk_sys_i);
    uv <= 1'b1;
    lowv <= 1'b1;
    wait_st(PSS_OFF, 3);
    wait_st(PSS_ON, 3);
    chk("copy", 8'h01, 8'(cpy));
    rdchk("coin", COIN_CTRL_OFFS, COIN_CTRL_RESET);
    rdchk("pwr", PWR_CTRL_OFFS, PWR_CTRL_RESET);
    wrap_up();
  end
endmodule : pss_ctrl_test
